// File: hdl/self_prog_pkg.sv
package self_prog_pkg;
	// variant: 0 = smaller part, 1 = larger part
	localparam bit LARGE_PART = 1'b1;
	localparam int PC_W = LARGE_PART ? 15 : 14;
	localparam int WORD_W = LARGE_PART ? 7 : 6;
	localparam int PAGE_W = PC_W - WORD_W;
	localparam int PAGE_WORDS = 1 << WORD_W;
	localparam int PC_TOP_BIT = PC_W - 1;
	localparam int PAGE_INDEX_TOP_BIT = WORD_W - 1;
	localparam int ZPTR_PC_TOP_BIT = PC_TOP_BIT + 1;
	localparam int ZPTR_PAGE_INDEX_TOP_BIT = PAGE_INDEX_TOP_BIT + 1;
	// control register bit positions
	localparam int CMD_EN_POS = 0;
	localparam int ERASE_POS = 1;
	localparam int WRITE_POS = 2;
	localparam int REEN_POS = 4;
	localparam int BUSY_POS = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// region boundary and boot start per fuse pattern
	localparam logic [15:0] SAFE_START_S = 16'h3800;
	localparam logic [15:0] SAFE_START_L = 16'h7000;
	localparam logic [15:0] BOOT11_S = 16'h3F00;
	localparam logic [15:0] BOOT11_L = 16'h7E00;
	localparam logic [15:0] BOOT10_S = 16'h3E00;
	localparam logic [15:0] BOOT10_L = 16'h7C00;
	localparam logic [15:0] BOOT01_S = 16'h3C00;
	localparam logic [15:0] BOOT01_L = 16'h7800;
	localparam logic [15:0] BOOT00_S = 16'h3800;
	localparam logic [15:0] BOOT00_L = 16'h7000;
	localparam int LOW_REGION_PAGES = 224;
	localparam int SAFE_REGION_PAGES = 32;
	// timed sequence window in cycles
	localparam int CMD_WINDOW = 4;
	// flash timing
	localparam int CLK_MHZ = 200;
	localparam int PROG_MIN_US = 3700;
	localparam int PROG_MAX_US = 4500;
	localparam int PROG_CYCLES_DEF = PROG_MIN_US * CLK_MHZ;
	localparam int TMR_W = 20;
endpackage

// File: hdl/self_prog_if.sv
`timescale 1ns/10ps
interface self_prog_if;
	import self_prog_pkg::*;
	logic        ctrl_wr;
	logic [7:0]  ctrl_wdata;
	logic [7:0]  self_prog_ctrl_reg;
	logic        spm_exec;
	logic [15:0] zptr;
	logic [7:0]  r0_data;
	logic [7:0]  r1_data;
	logic        load_rd;
	logic [7:0]  load_data;
	logic [PC_W-1:0] fetch_addr;
	logic        fetch_ok;
	logic        nv_data_write_busy;
	modport dev (
		input  ctrl_wr, ctrl_wdata, spm_exec, zptr, r0_data, r1_data,
		input  load_rd, fetch_addr, nv_data_write_busy,
		output self_prog_ctrl_reg, load_data, fetch_ok
	);
	modport cpu (
		output ctrl_wr, ctrl_wdata, spm_exec, zptr, r0_data, r1_data,
		output load_rd, fetch_addr,
		input  self_prog_ctrl_reg, load_data, fetch_ok, nv_data_write_busy
	);
endinterface

// File: hdl/self_prog_dev.sv
`timescale 1ns/10ps
// Summary of operation
// - boot fuses select boot section size
// - only top region readable during programming
// - top 32 pages never read-while-write
// - program counter 14 or 15 bits
// - pages of 64 or 128 words
// - z pointer is word address times two
// - page number from z above word
// - buffer word from z; zero on write
// - software keeps z bit zero clear
// - z bit zero selects read byte
// - busy program blocks low region fetches
// - busy bit set while region unreadable
// - reenable plus enable restores region reads
// - software waits for enable clear
// - software waits data memory not busy
// - enable alone loads one buffer word
// - erase or write selected page
// - software masks interrupts around sequence
// - store within four cycles else dropped
// - busy clears only by reenable command
// - erase and write take 3.7 ms
module self_prog_dev
	import self_prog_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	self_prog_if.dev        bus,
	input  wire logic       boot_size_fuse_hi,
	input  wire logic       boot_size_fuse_lo,
	output      logic [15:0] boot_start,
	output      logic        erase_pulse,
	output      logic        write_pulse,
	output      logic [PAGE_W-1:0] flash_page
);

	typedef enum logic [1:0] {IDLE, ARMED, PROG} phase_e;

	typedef struct packed {
		phase_e                  phase;
		logic [2:0]              win;
		logic [2:0]              cmd;
		logic                    cmd_en;
		logic                    busy;
		logic [TMR_W-1:0]        tmr;
		logic [PAGE_W-1:0]       page;
		logic                    erase;
		logic                    write;
		logic [7:0]              load_data;
		// registered so a fuse change settles in one cycle
		logic [15:0]             boot;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// whole array modelled; erase and write touch one page per pulse
	logic [15:0] mem [0:(1<<PC_W)-1];
	logic [15:0] buf_mem [0:PAGE_WORDS-1];

	////////////////////////////////////////////////////////////////
	// true for words that stay readable while a page is programmed
	function automatic logic in_safe_region(input logic [PC_W-1:0] a);
		logic [15:0] w;
		w = 16'(a);
		return LARGE_PART ? (w >= SAFE_START_L) : (w >= SAFE_START_S);
	endfunction

	// fuse pair to boot section start; 2'b11 gives the smallest one
	function automatic logic [15:0] boot_base(input logic [1:0] fuse);
		logic [15:0] b;
		b = 16'h0000;
		unique case (fuse)
			2'b11: b = LARGE_PART ? BOOT11_L : BOOT11_S;
			2'b10: b = LARGE_PART ? BOOT10_L : BOOT10_S;
			2'b01: b = LARGE_PART ? BOOT01_L : BOOT01_S;
			2'b00: b = LARGE_PART ? BOOT00_L : BOOT00_S;
		endcase
		return b;
	endfunction

	////////////////////////////////////////////////////////////////
	logic [WORD_W-1:0] zword;
	logic [PAGE_W-1:0] zpage;
	logic [PC_W-1:0]   zpc;
	logic              spm_ok;

	assign zpc = bus.zptr[ZPTR_PC_TOP_BIT:1];
	assign zword = bus.zptr[ZPTR_PAGE_INDEX_TOP_BIT:1];
	assign zpage = bus.zptr[ZPTR_PC_TOP_BIT:ZPTR_PAGE_INDEX_TOP_BIT+1];
	// a store outside the armed window is dropped
	assign spm_ok = bus.spm_exec && st_r.phase == ARMED;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.erase = 1'b0;
		st_nxt.write = 1'b0;
		st_nxt.boot = boot_base({boot_size_fuse_hi,
			boot_size_fuse_lo});
		unique case (st_r.phase)
			IDLE: begin
				// data-memory write blocks any arming
				// command bits frozen until the command ends
				if (bus.ctrl_wr && !bus.nv_data_write_busy &&
					bus.ctrl_wdata[CMD_EN_POS]) begin
					st_nxt.phase = ARMED;
					st_nxt.cmd_en = 1'b1;
					st_nxt.win = 3'(CMD_WINDOW - 1);
					st_nxt.cmd = {bus.ctrl_wdata[REEN_POS],
						bus.ctrl_wdata[WRITE_POS], bus.ctrl_wdata[ERASE_POS]};
				end
			end
			ARMED: begin
				// window counts the edges after the write edge
				if (spm_ok) begin
					if (st_r.cmd[2]) begin
						st_nxt.busy = 1'b0;
						st_nxt.cmd_en = 1'b0;
						st_nxt.phase = IDLE;
					end else if (st_r.cmd[1:0] != 2'b00) begin
						st_nxt.page = zpage;
						st_nxt.busy = 1'b1;
						st_nxt.tmr = TMR_W'(PROG_CYCLES - 1);
						st_nxt.phase = PROG;
					end else begin
						st_nxt.cmd_en = 1'b0;
						st_nxt.phase = IDLE;
					end
				end else if (st_r.win == 3'h0) begin
					st_nxt.cmd_en = 1'b0;
					st_nxt.phase = IDLE;
				end else begin
					st_nxt.win = st_r.win - 3'h1;
				end
			end
			PROG: begin
				// busy outlives enable until a reenable command
				if (st_r.tmr == '0) begin
					st_nxt.erase = st_r.cmd[0];
					st_nxt.write = st_r.cmd[1] && !st_r.cmd[0];
					st_nxt.cmd_en = 1'b0;
					st_nxt.phase = IDLE;
				end else begin
					st_nxt.tmr = st_r.tmr - TMR_W'(1);
				end
			end
		endcase
		if (bus.load_rd) begin
			// low region reads as ones while it is blocked
			if (st_r.busy && !in_safe_region(zpc))
				st_nxt.load_data = 8'hFF;
			else if (bus.zptr[0])
				st_nxt.load_data = mem[zpc][15:8];
			else
				st_nxt.load_data = mem[zpc][7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{phase: IDLE, win: 3'h0, cmd: 3'h0, cmd_en: 1'b0,
				busy: 1'b0, tmr: '0, page: '0, erase: 1'b0,
				write: 1'b0, load_data: 8'h00, boot: 16'h0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// flash array and page buffer; no reset by nature
	// a page write leaves the buffer as it was
	always_ff @(posedge clk) begin
		if (spm_ok && st_r.cmd == 3'b000)
			buf_mem[zword] <= {bus.r1_data, bus.r0_data};
		if (st_r.erase) begin
			for (int i = 0; i < PAGE_WORDS; i++)
				mem[{st_r.page, WORD_W'(i)}] <= 16'hFFFF;
		end
		if (st_r.write) begin
			// word field ignored: page base used
			for (int i = 0; i < PAGE_WORDS; i++)
				mem[{st_r.page, WORD_W'(i)}] <= buf_mem[i];
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		bus.self_prog_ctrl_reg = CTRL_RESET;
		bus.self_prog_ctrl_reg[CMD_EN_POS] = st_r.cmd_en;
		bus.self_prog_ctrl_reg[ERASE_POS] = st_r.cmd_en && st_r.cmd[0];
		bus.self_prog_ctrl_reg[WRITE_POS] = st_r.cmd_en && st_r.cmd[1];
		bus.self_prog_ctrl_reg[REEN_POS] = st_r.cmd_en && st_r.cmd[2];
		bus.self_prog_ctrl_reg[BUSY_POS] = st_r.busy;
	end

	assign bus.load_data = st_r.load_data;
	// combinational so a blocked fetch is refused in its own cycle
	assign bus.fetch_ok = !st_r.busy ||
		in_safe_region(bus.fetch_addr);
	assign boot_start = st_r.boot;
	assign erase_pulse = st_r.erase;
	assign write_pulse = st_r.write;
	assign flash_page = st_r.page;

endmodule

// File: hdl/self_prog_cpu.sv
`timescale 1ns/10ps
module self_prog_cpu
	import self_prog_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	self_prog_if.cpu        bus,
	input  wire logic       req,
	input  wire logic [7:0] req_ctrl,
	input  wire logic [15:0] req_z,
	input  wire logic [15:0] req_data,
	input  wire logic       irq_en_in,
	input  wire logic       load_req,
	input  wire logic [PC_W-1:0] fetch_pc,
	output      logic       ready,
	output      logic       irq_mask
);

	typedef enum logic [2:0] {IDLE, WAIT_EN, WAIT_EE, WR_CTRL, EXEC} step_e;

	typedef struct packed {
		step_e       step;
		logic [7:0]  ctrl;
		logic [15:0] z;
		logic [15:0] data;
		logic        mask;
		logic        wr;
		logic        spm;
		logic        load;
		logic [PC_W-1:0] pc;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.wr = 1'b0;
		st_nxt.spm = 1'b0;
		st_nxt.load = load_req;
		st_nxt.pc = fetch_pc;
		unique case (st_r.step)
			IDLE: begin
				// full pointer for loads; byte select kept
				st_nxt.z = req_z;
				if (req) begin
					st_nxt.ctrl = req_ctrl;
					st_nxt.z = {req_z[15:1], 1'b0};
					st_nxt.data = req_data;
					st_nxt.step = WAIT_EN;
				end
			end
			WAIT_EN: begin
				if (!bus.self_prog_ctrl_reg[CMD_EN_POS])
					st_nxt.step = WAIT_EE;
			end
			WAIT_EE: begin
				st_nxt.mask = 1'b1;
				if (!bus.nv_data_write_busy) begin
					st_nxt.wr = 1'b1;
					st_nxt.step = WR_CTRL;
				end
			end
			WR_CTRL: begin
				st_nxt.spm = 1'b1;
				st_nxt.step = EXEC;
			end
			EXEC: begin
				st_nxt.mask = 1'b0;
				st_nxt.step = IDLE;
			end
			default: st_nxt.step = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{step: IDLE, ctrl: 8'h00, z: 16'h0000,
				data: 16'h0000, mask: 1'b0, wr: 1'b0, spm: 1'b0,
				load: 1'b0, pc: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.ctrl_wr = st_r.wr;
	assign bus.ctrl_wdata = st_r.ctrl;
	assign bus.spm_exec = st_r.spm;
	assign bus.zptr = st_r.z;
	assign bus.r0_data = st_r.data[7:0];
	assign bus.r1_data = st_r.data[15:8];
	assign bus.load_rd = st_r.load;
	assign bus.fetch_addr = st_r.pc;
	assign ready = st_r.step == IDLE;
	assign irq_mask = st_r.mask || !irq_en_in;

endmodule

// File: tb/flash_self_program_control_sva.sv
`timescale 1ns/10ps
module flash_self_program_control_sva
	import self_prog_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            ctrl_wr,
	input wire logic [7:0]      ctrl_wdata,
	input wire logic [7:0]      self_prog_ctrl_reg,
	input wire logic            spm_exec,
	input wire logic [PC_W-1:0] fetch_addr,
	input wire logic            fetch_ok,
	input wire logic            nv_data_write_busy
);
	localparam logic [PC_W-1:0] SAFE_A =
		PC_W'(LARGE_PART ? SAFE_START_L : SAFE_START_S);
	logic en;
	logic busy;
	logic prog;
	logic reen;
	logic cmd;
	assign en = self_prog_ctrl_reg[CMD_EN_POS];
	assign busy = self_prog_ctrl_reg[BUSY_POS];
	assign prog = self_prog_ctrl_reg[ERASE_POS] | self_prog_ctrl_reg[WRITE_POS];
	assign reen = self_prog_ctrl_reg[REEN_POS];
	assign cmd = en & spm_exec;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	property p_arm;
		ctrl_wr && ctrl_wdata[0] && !nv_data_write_busy && !en |=> en;
	endproperty
	a_arm: assert property (p_arm) else $error("enable not set");
	property p_nv;
		ctrl_wr && nv_data_write_busy && !en |=> !en;
	endproperty
	a_nv: assert property (p_nv) else $error("armed while busy");
	// missing store within four edges must disarm
	property p_window;
		$rose(en) ##0 (!spm_exec)[*4] |=> !en;
	endproperty
	a_window: assert property (p_window) else $error("window");
	property p_fill;
		cmd && !prog && !reen |=> !en;
	endproperty
	a_fill: assert property (p_fill) else $error("fill stuck");
	property p_busy_set;
		cmd && prog |=> busy && en;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("no busy");
	property p_busy_hold;
		busy && !(cmd && reen) |=> busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy");
	property p_reen;
		cmd && reen && !prog |=> !busy && !en;
	endproperty
	a_reen: assert property (p_reen) else $error("reenable");
	property p_hold;
		$rose(busy) |-> en[*8];
	endproperty
	a_hold: assert property (p_hold) else $error("enable dropped");
	property p_fetch;
		fetch_ok == !(busy && fetch_addr < SAFE_A);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch gate");
endmodule

// File: tb/flash_self_program_control_tb_top.sv
`timescale 1ns/10ps
module flash_self_program_control_tb_top;
	import self_prog_pkg::*;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              req = 1'b0;
	logic [7:0]        req_ctrl = 8'h00;
	logic [15:0]       req_z = 16'h0000;
	logic [15:0]       req_data = 16'h0000;
	logic              irq_en_in = 1'b1;
	logic              load_req = 1'b0;
	logic [PC_W-1:0]   fetch_pc = '0;
	logic [PC_W-1:0]   safe_pc =
		PC_W'(LARGE_PART ? SAFE_START_L : SAFE_START_S);
	logic              nv_busy = 1'b0;
	logic              fuse_hi = 1'b1;
	logic              fuse_lo = 1'b1;
	logic [15:0]       boot_start;
	logic              erase_pulse;
	logic              write_pulse;
	logic              ready;
	logic              irq_mask;
	logic [PAGE_W-1:0] flash_page;
	logic [PAGE_W-1:0] pg;
	logic              saw_e;
	logic              saw_w;
	logic              saw_m;
	int                mismatches = 0;
	int                comparisons = 0;
	int                cycles = 0;
	logic [1:0]        fuse_row [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
	logic [15:0]       boot_row [4] = '{
		LARGE_PART ? BOOT11_L : BOOT11_S, LARGE_PART ? BOOT10_L : BOOT10_S,
		LARGE_PART ? BOOT01_L : BOOT01_S, LARGE_PART ? BOOT00_L : BOOT00_S};
	self_prog_if bus_if ();
	assign bus_if.nv_data_write_busy = nv_busy;
	// short program time keeps the run brief
	self_prog_dev #(.PROG_CYCLES(20)) self_prog_dev_i (.clk(clk),
		.rst_n(rst_n), .bus(bus_if), .boot_size_fuse_hi(fuse_hi),
		.boot_size_fuse_lo(fuse_lo), .boot_start(boot_start),
		.erase_pulse(erase_pulse), .write_pulse(write_pulse),
		.flash_page(flash_page));
	self_prog_cpu self_prog_cpu_i (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.req(req), .req_ctrl(req_ctrl), .req_z(req_z), .req_data(req_data),
		.irq_en_in(irq_en_in), .load_req(load_req), .fetch_pc(fetch_pc),
		.ready(ready), .irq_mask(irq_mask));
	flash_self_program_control_sva flash_self_program_control_sva_i (
		.clk(clk), .rst_n(rst_n), .ctrl_wr(bus_if.ctrl_wr),
		.ctrl_wdata(bus_if.ctrl_wdata),
		.self_prog_ctrl_reg(bus_if.self_prog_ctrl_reg),
		.spm_exec(bus_if.spm_exec), .fetch_addr(bus_if.fetch_addr),
		.fetch_ok(bus_if.fetch_ok),
		.nv_data_write_busy(bus_if.nv_data_write_busy));
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task stop_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task start(input logic [7:0] c, input logic [15:0] z);
		req = 1'b1;
		req_ctrl = c;
		req_z = z;
		@(posedge clk);
		#1 req = 1'b0;
	endtask
	// exit needs both ready and enable clear, not just ready
	task wait_done;
		saw_e = 1'b0;
		saw_w = 1'b0;
		saw_m = 1'b0;
		for (int n = 0; n < 200; n++) begin
			@(posedge clk);
			#1 saw_m = saw_m | irq_mask;
			if (erase_pulse === 1'b1) begin
				saw_e = 1'b1;
				pg = flash_page;
			end
			if (write_pulse === 1'b1) begin
				saw_w = 1'b1;
				pg = flash_page;
			end
			if (n > 2 && ready === 1'b1
				&& bus_if.self_prog_ctrl_reg[CMD_EN_POS] === 1'b0) return;
		end
		check(1'b0, "command hang");
	endtask
	task run(input logic [7:0] c, input logic [15:0] z);
		start(c, z);
		wait_done();
	endtask
	// pointer registered in the cpu, byte ready one edge later
	task load_at(input logic [15:0] z);
		req_z = z;
		load_req = 1'b1;
		@(posedge clk);
		#1 load_req = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task fetch_at(input logic [PC_W-1:0] a);
		fetch_pc = a;
		@(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			check(1'b0, "timeout");
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		check(bus_if.self_prog_ctrl_reg === CTRL_RESET, "ctrl reset");
		for (int i = 0; i < 4; i++) begin
			{fuse_hi, fuse_lo} = fuse_row[i];
			repeat (2) @(posedge clk);
			#1 check(boot_start === boot_row[i], "boot start");
		end
		run(8'h03, 16'(3) << (WORD_W + 1));
		check(saw_e === 1'b1 && pg === PAGE_W'(3), "erase page");
		check(bus_if.self_prog_ctrl_reg[BUSY_POS] === 1'b1, "busy");
		check(saw_m === 1'b1, "irq mask");
		run(8'h11, 16'h0000);
		check(bus_if.self_prog_ctrl_reg[BUSY_POS] === 1'b0, "reen");
		req_data = 16'hA55A;
		run(8'h01, 16'h00FE);
		check(saw_e === 1'b0 && saw_w === 1'b0, "fill");
		run(8'h05, 16'hFFFF << (WORD_W + 1));
		check(saw_w === 1'b1 && pg === '1, "top page write");
		run(8'h07, 16'h0000);
		check(saw_e === 1'b1 && saw_w === 1'b0, "erase wins");
		fetch_at(safe_pc - 1'b1);
		check(bus_if.fetch_ok === 1'b0, "low fetch open");
		fetch_at(safe_pc);
		check(bus_if.fetch_ok === 1'b1, "high fetch shut");
		load_at(16'hFFFF);
		check(bus_if.load_data === 8'hA5, "load high");
		run(8'h11, 16'h0000);
		load_at(16'hFFFE);
		check(bus_if.load_data === 8'h5A, "load low");
		nv_busy = 1'b1;
		start(8'h01, 16'h0000);
		repeat (10) @(posedge clk);
		#1 check(bus_if.self_prog_ctrl_reg[CMD_EN_POS] === 1'b0, "nv");
		nv_busy = 1'b0;
		wait_done();
		// busy rises in the write cycle itself: device must refuse
		start(8'h03, 16'h0000);
		repeat (2) @(posedge clk);
		#1 nv_busy = 1'b1;
		repeat (3) @(posedge clk);
		#1 check(bus_if.self_prog_ctrl_reg === CTRL_RESET, "nv ok");
		nv_busy = 1'b0;
		fetch_at('0);
		check(bus_if.fetch_ok === 1'b1, "fetch idle");
		stop_test();
	end
endmodule
